// ---- include/spli_pkg.sv ----
// Purpose: shared constants and types of the startup phase lamp indicator
// Assumes: 100 MHz module clock
// Notes: lamp vectors are ordered fault, run, stop, backplane, transmit, receive (msb first)
package spli_pkg;
   localparam int unsigned CLOCK_HZ = 100_000_000;
   localparam int unsigned CLOCK_KHZ = CLOCK_HZ / 1000;
   localparam int unsigned FLASH_HALF_MS = 250;
   localparam int unsigned FLASH_HALF_CYCLES = CLOCK_KHZ * FLASH_HALF_MS;
   localparam int unsigned SECOND_S = 1;
   localparam int unsigned SECOND_CYCLES = CLOCK_HZ * SECOND_S;
   localparam logic [3:0] ACK_FLASH_S = 4'hA;
   localparam logic [3:0] RESET_DELAY_S = 4'hA;
   localparam logic [1:0] BLINK_HALF_TICKS = 2'h2;

   localparam logic [3:0] PHASE_POWER_ON = 4'h1;
   localparam logic [3:0] PHASE_OS_LOAD = 4'h2;
   localparam logic [3:0] PHASE_OS_START = 4'h3;
   localparam logic [3:0] PHASE_FW_LOAD = 4'h4;
   localparam logic [3:0] PHASE_CODE_BASE = 4'h5;
   localparam logic [3:0] PHASE_LAST = 4'hC;

   localparam int LAMP_FAULT = 5;
   localparam int LAMP_RUN = 4;
   localparam int LAMP_STOP = 3;
   localparam int LAMP_BACKPLANE = 2;
   localparam int LAMP_TRANSMIT = 1;
   localparam int LAMP_RECEIVE = 0;
   localparam logic [5:0] LAMPS_NONE = 6'h00;
   localparam logic [5:0] LAMPS_ALL = 6'h3F;
   localparam logic [2:0] CODE_ALL = 3'h7;

   localparam logic [2:0] OUTCOME_OK = 3'h0;
   localparam logic [2:0] OUTCOME_ERROR = 3'h1;
   localparam logic [2:0] OUTCOME_NO_PARAM = 3'h2;
   localparam logic [2:0] OUTCOME_NO_FW = 3'h3;
   localparam logic [2:0] OUTCOME_NONE = 3'h4;

   localparam logic [6:0] DEFAULT_STATION_ADDR = 7'h03;
   localparam logic [6:0] STATION_ADDR_NONE = 7'h00;
   localparam logic [7:0] LOG_CODE_NONE = 8'h00;
   localparam logic [3:0] SEC_ZERO = 4'h0;
   localparam logic [3:0] PHASE_NONE = 4'h0;

   typedef enum logic [3:0] {
      SPLI_ST_PHASE = 4'b0000,
      SPLI_ST_OK = 4'b0001,
      SPLI_ST_ERROR = 4'b0010,
      SPLI_ST_NO_PARAM = 4'b0011,
      SPLI_ST_NO_FW = 4'b0100,
      SPLI_ST_NONE = 4'b0101,
      SPLI_ST_DEFAULT = 4'b0110,
      SPLI_ST_ACK = 4'b0111,
      SPLI_ST_WAIT = 4'b1000
   } spli_state_t;
endpackage : spli_pkg

// ---- include/spli_tick_if.sv ----
// Purpose: carries the common flash phase and time ticks between the indicator's modules
// Assumes: one clock domain
// Notes: all signals are registered by the generator
interface spli_tick_if;
   logic flash_on;
   logic half_tick;
   logic sec_tick;
   modport gen (output flash_on, output half_tick, output sec_tick);
   modport use_side (input flash_on, input half_tick, input sec_tick);
endinterface : spli_tick_if

// ---- rtl/spli_flash_gen.sv ----
// Purpose: common flash square wave and one second tick
// Assumes: synchronous active low reset already released cleanly
// Notes: one shared toggle keeps every flashing lamp in phase
module spli_flash_gen
   import spli_pkg::*;
#(
   parameter int unsigned HALF_CYCLES = FLASH_HALF_CYCLES,
   parameter int unsigned SEC_CYCLES = SECOND_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   spli_tick_if.gen ticks
);
   typedef struct packed {
      logic [31:0] half_cnt;
      logic [31:0] sec_cnt;
      logic flash_on;
      logic half_tick;
      logic sec_tick;
   } spli_flash_t;

   spli_flash_t r;
   spli_flash_t next_r;

   always_comb begin
      next_r = r;
      next_r.half_tick = 1'b0;
      next_r.sec_tick = 1'b0;
      // 50 percent duty: equal on and off halves
      if (r.half_cnt == 32'(HALF_CYCLES - 1)) begin
         next_r.half_cnt = '0;
         next_r.flash_on = ~r.flash_on; // R21
         next_r.half_tick = 1'b1;
      end else begin
         next_r.half_cnt = r.half_cnt + 32'h1;
      end
      if (r.sec_cnt == 32'(SEC_CYCLES - 1)) begin
         next_r.sec_cnt = '0;
         next_r.sec_tick = 1'b1;
      end else begin
         next_r.sec_cnt = r.sec_cnt + 32'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign ticks.flash_on = r.flash_on;
   assign ticks.half_tick = r.half_tick;
   assign ticks.sec_tick = r.sec_tick;
endmodule : spli_flash_gen

// ---- rtl/spli_top.sv ----
// Purpose: startup phase lamp indicator with fault report and parameter reset countdown
// Assumes: phase, outcome and event inputs synchronous to clock; button high while pressed
// Notes: lamp outputs are registered; flash rate and second length are parameters
// Contract
// [R01] phase 1 lights all six startup lamps
// [R02] phase 2: group fault off, other five lit
// [R03] phase 3: group fault and run off, remaining four lit
// [R04] phase 4: fault, run, stop off; backplane, transmit, receive lit
// [R05] phases 5 to 12: fault off, run flashing, stop steady
// [R06] phases 5 to 12 show phase minus 5 in binary on three lamps
// [R07] clean completion: run lit, fault and stop off, lower lamps normal meaning
// [R08] error completion: fault and stop lit, run dark, lower lamps frozen
// [R09] missing parameters: stop lit, backplane and transmit flash, receive lit
// [R10] no firmware or neither: stop lit, given lamps flash
// [R11] default startup done: run and stop flash, lower three lit
// [R12] link and traffic lamps carry no startup meaning
// [R13] startup problem lights fault, interrupts host, logs diagnostic entry
// [R14] new parameter set: fault lamp flashes about ten seconds
// [R15] ten seconds later self reset and restart startup from power on
// [R16] button held at power on: fault blinks off then on in phase 1
// [R17] operator holds button through power on, releases after the blink
// [R18] after default startup accept parameters on multipoint bus and ethernet
// [R19] default startup behind certain hosts forces station address 3
// [R20] configuring party restarts device after supplying parameters
// [R21] flashing lamps share one rate, half duty, in phase
module spli_top
   import spli_pkg::*;
#(
   parameter int unsigned HALF_CYCLES = FLASH_HALF_CYCLES,
   parameter int unsigned SEC_CYCLES = SECOND_CYCLES
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic phase_valid,
   input wire logic [3:0] phase_num,
   input wire logic outcome_valid,
   input wire logic [2:0] outcome_code,
   input wire logic problem_valid,
   input wire logic [7:0] problem_code,
   input wire logic param_received,
   input wire logic reset_button,
   input wire logic fixed_addr_host,
   input wire logic [2:0] normal_lamps,
   output logic group_fault_lamp,
   output logic run_lamp,
   output logic stop_lamp,
   output logic backplane_bus_lamp,
   output logic transmit_lamp,
   output logic receive_lamp,
   output logic diag_irq,
   output logic diag_log_valid,
   output logic [7:0] diag_log_code,
   output logic self_reset_req,
   output logic default_mode,
   output logic accept_multipoint_param,
   output logic accept_ethernet_param,
   output logic station_addr_force,
   output logic [6:0] station_addr
);
   typedef struct packed {
      spli_state_t state;
      spli_state_t ret_state;
      logic [3:0] phase;
      logic [3:0] err_phase;
      logic fault;
      logic default_mode;
      logic strap_done;
      logic blink_active;
      logic [1:0] blink_cnt;
      logic [3:0] sec_cnt;
      logic [5:0] lamps;
      logic diag_irq;
      logic log_valid;
      logic [7:0] log_code;
      logic self_reset;
      logic accept;
      logic addr_force;
      logic [6:0] addr;
   } spli_top_t;

   logic [1:0] rst_sync;
   logic rst_n;
   spli_top_t r;
   spli_top_t next_r;
   spli_tick_if ticks ();

   // only the second stage is used; the first may be metastable
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   spli_flash_gen #(
      .HALF_CYCLES(HALF_CYCLES),
      .SEC_CYCLES(SEC_CYCLES)
   ) u_flash (
      .clock(clock),
      .rst_n(rst_n),
      .ticks(ticks)
   );

   // three lower lamps during a running phase; the backplane lamp (vector bit 2) carries the code's low bit
   function automatic logic [2:0] phase_code(input logic [3:0] ph);
      logic [3:0] diff;
      diff = ph - PHASE_CODE_BASE;
      if (ph < PHASE_CODE_BASE) begin
         phase_code = CODE_ALL; // R01 R02 R03 R04
      end else begin
         phase_code = {diff[0], diff[1], diff[2]}; // R06
      end
   endfunction : phase_code

   // returns {steady mask, flash mask} for a display state
   function automatic logic [11:0] display(
      input spli_state_t st,
      input logic [3:0] ph,
      input logic [3:0] eph,
      input logic [2:0] normal
   );
      logic [5:0] steady;
      logic [5:0] flash;
      steady = LAMPS_NONE;
      flash = LAMPS_NONE;
      case (st)
         SPLI_ST_PHASE: begin
            steady[2:0] = phase_code(ph);
            if (ph == PHASE_POWER_ON) begin
               steady = LAMPS_ALL; // R01
            end else if (ph == PHASE_OS_LOAD) begin
               steady[LAMP_RUN] = 1'b1; // R02
               steady[LAMP_STOP] = 1'b1; // R02
            end else if (ph == PHASE_OS_START) begin
               steady[LAMP_STOP] = 1'b1; // R03
            end else if (ph == PHASE_FW_LOAD) begin
               steady[LAMP_STOP] = 1'b0; // R04
            end else begin
               steady[LAMP_STOP] = 1'b1; // R05
               flash[LAMP_RUN] = 1'b1; // R05
            end
         end
         SPLI_ST_OK: begin
            steady[LAMP_RUN] = 1'b1; // R07
            steady[2:0] = normal; // R07
         end
         SPLI_ST_ERROR: begin
            steady[LAMP_FAULT] = 1'b1; // R08
            steady[LAMP_STOP] = 1'b1; // R08
            steady[2:0] = phase_code(eph); // R08
         end
         SPLI_ST_NO_PARAM: begin
            steady[LAMP_STOP] = 1'b1; // R09
            steady[LAMP_RECEIVE] = 1'b1; // R09
            flash[LAMP_BACKPLANE] = 1'b1; // R09
            flash[LAMP_TRANSMIT] = 1'b1; // R09
         end
         SPLI_ST_NO_FW: begin
            steady[LAMP_STOP] = 1'b1; // R10
            steady[LAMP_BACKPLANE] = 1'b1; // R10
            flash[LAMP_TRANSMIT] = 1'b1; // R10
            flash[LAMP_RECEIVE] = 1'b1; // R10
         end
         SPLI_ST_NONE: begin
            steady[LAMP_STOP] = 1'b1; // R10
            flash[2:0] = CODE_ALL; // R10
         end
         SPLI_ST_DEFAULT: begin
            flash[LAMP_RUN] = 1'b1; // R11
            flash[LAMP_STOP] = 1'b1; // R11
            steady[2:0] = CODE_ALL; // R11
         end
         default: begin
            steady = LAMPS_NONE;
            flash = LAMPS_NONE;
         end
      endcase
      display = {steady, flash};
   endfunction : display

   function automatic logic is_done(input spli_state_t st);
      case (st)
         SPLI_ST_OK, SPLI_ST_ERROR, SPLI_ST_NO_PARAM, SPLI_ST_NO_FW, SPLI_ST_NONE, SPLI_ST_DEFAULT: begin
            is_done = 1'b1;
         end
         default: begin
            is_done = 1'b0;
         end
      endcase
   endfunction : is_done

   always_comb begin
      logic [11:0] masks;
      logic [5:0] lamps;
      spli_state_t shown;
      masks = '0;
      lamps = LAMPS_NONE;
      shown = SPLI_ST_PHASE;
      next_r = r;
      next_r.diag_irq = 1'b0;
      next_r.log_valid = 1'b0;
      next_r.self_reset = 1'b0;

      // strap caught once, in the first cycle after reset release
      if (!r.strap_done) begin
         next_r.strap_done = 1'b1;
         next_r.default_mode = reset_button; // R17
         next_r.blink_active = reset_button; // R16
         next_r.blink_cnt = '0;
      end

      // off for a fixed number of half flash periods, then back on
      if (r.blink_active && ticks.half_tick) begin
         if (r.blink_cnt == BLINK_HALF_TICKS - 2'h1) begin
            next_r.blink_active = 1'b0; // R16
         end else begin
            next_r.blink_cnt = r.blink_cnt + 2'h1;
         end
      end

      case (r.state)
         SPLI_ST_PHASE: begin
            if (phase_valid && phase_num >= PHASE_POWER_ON && phase_num <= PHASE_LAST) begin
               next_r.phase = phase_num;
            end
            if (outcome_valid) begin
               case (outcome_code)
                  OUTCOME_OK: begin
                     next_r.state = r.default_mode ? SPLI_ST_DEFAULT : SPLI_ST_OK; // R11
                  end
                  OUTCOME_ERROR: begin
                     next_r.state = SPLI_ST_ERROR;
                     next_r.err_phase = r.phase; // R08
                  end
                  OUTCOME_NO_PARAM: begin
                     next_r.state = SPLI_ST_NO_PARAM;
                  end
                  OUTCOME_NO_FW: begin
                     next_r.state = SPLI_ST_NO_FW;
                  end
                  OUTCOME_NONE: begin
                     next_r.state = SPLI_ST_NONE;
                  end
                  default: begin
                     next_r.state = r.state;
                  end
               endcase
            end
         end
         SPLI_ST_ACK: begin
            if (ticks.sec_tick) begin
               if (r.sec_cnt == ACK_FLASH_S - 4'h1) begin
                  next_r.state = SPLI_ST_WAIT; // R14
                  next_r.sec_cnt = SEC_ZERO;
               end else begin
                  next_r.sec_cnt = r.sec_cnt + 4'h1;
               end
            end
         end
         SPLI_ST_WAIT: begin
            if (ticks.sec_tick) begin
               if (r.sec_cnt == RESET_DELAY_S - 4'h1) begin
                  // behaves as after power on, but the button is not sampled again
                  next_r.state = SPLI_ST_PHASE; // R15
                  next_r.phase = PHASE_POWER_ON; // R15
                  next_r.self_reset = 1'b1; // R15
                  next_r.fault = 1'b0;
                  next_r.default_mode = 1'b0;
                  next_r.sec_cnt = SEC_ZERO;
               end else begin
                  next_r.sec_cnt = r.sec_cnt + 4'h1;
               end
            end
         end
         default: begin
            if (param_received) begin
               next_r.ret_state = r.state;
               next_r.state = SPLI_ST_ACK; // R14
               next_r.sec_cnt = SEC_ZERO;
            end
         end
      endcase

      // problems count only while the phases run; in the cycle self_reset_req is high the state is already back in the phases
      if (problem_valid && r.state == SPLI_ST_PHASE) begin
         next_r.fault = 1'b1; // R13
         next_r.diag_irq = 1'b1; // R13
         next_r.log_valid = 1'b1; // R13
         next_r.log_code = problem_code; // R13
      end

      // the countdown shows the outcome that was reached before the transfer
      shown = (r.state == SPLI_ST_ACK || r.state == SPLI_ST_WAIT) ? r.ret_state : r.state;
      masks = display(shown, r.phase, r.err_phase, normal_lamps);
      lamps = masks[11:6] | (masks[5:0] & {6{ticks.flash_on}}); // R21
      if (r.state == SPLI_ST_PHASE && r.fault) begin
         lamps[LAMP_FAULT] = 1'b1; // R13
      end
      if (r.state == SPLI_ST_PHASE && r.phase == PHASE_POWER_ON && r.blink_active) begin
         lamps[LAMP_FAULT] = 1'b0; // R16
      end
      if (r.state == SPLI_ST_ACK) begin
         lamps[LAMP_FAULT] = ticks.flash_on; // R14
      end
      // link and traffic lamps are left to the network logic and not driven here
      next_r.lamps = lamps; // R12

      // after a default start the device waits for the configuring party to restart it
      next_r.accept = is_done(r.state); // R20
      next_r.addr_force = r.default_mode && fixed_addr_host && r.state == SPLI_ST_DEFAULT; // R19
      next_r.addr = next_r.addr_force ? DEFAULT_STATION_ADDR : STATION_ADDR_NONE; // R19
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         r.state <= SPLI_ST_PHASE;
         r.ret_state <= SPLI_ST_PHASE;
         r.phase <= PHASE_POWER_ON;
         r.err_phase <= PHASE_NONE;
         r.fault <= 1'b0;
         r.default_mode <= 1'b0;
         r.strap_done <= 1'b0;
         r.blink_active <= 1'b0;
         r.blink_cnt <= '0;
         r.sec_cnt <= SEC_ZERO;
         r.lamps <= LAMPS_ALL;
         r.diag_irq <= 1'b0;
         r.log_valid <= 1'b0;
         r.log_code <= LOG_CODE_NONE;
         r.self_reset <= 1'b0;
         r.accept <= 1'b0;
         r.addr_force <= 1'b0;
         r.addr <= STATION_ADDR_NONE;
      end else begin
         r <= next_r;
      end
   end

   assign group_fault_lamp = r.lamps[LAMP_FAULT];
   assign run_lamp = r.lamps[LAMP_RUN];
   assign stop_lamp = r.lamps[LAMP_STOP];
   assign backplane_bus_lamp = r.lamps[LAMP_BACKPLANE];
   assign transmit_lamp = r.lamps[LAMP_TRANSMIT];
   assign receive_lamp = r.lamps[LAMP_RECEIVE];
   assign diag_irq = r.diag_irq;
   assign diag_log_valid = r.log_valid;
   assign diag_log_code = r.log_code;
   assign self_reset_req = r.self_reset;
   assign default_mode = r.default_mode;
   // parameters are taken over either path once a startup outcome stands
   assign accept_multipoint_param = r.accept; // R18
   assign accept_ethernet_param = r.accept; // R18
   assign station_addr_force = r.addr_force;
   assign station_addr = r.addr;
endmodule : spli_top

// ---- testbench/spli_properties.sv ----
// Purpose: port level assertions of the startup lamp indicator
// Assumes: one clock domain, arst_n low resets everything
// Notes: lamp patterns per phase are judged by the bench; pulses and pairings here
module spli_properties
   import spli_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic outcome_valid,
   input wire logic problem_valid,
   input wire logic [7:0] problem_code,
   input wire logic group_fault_lamp,
   input wire logic run_lamp,
   input wire logic stop_lamp,
   input wire logic backplane_bus_lamp,
   input wire logic transmit_lamp,
   input wire logic receive_lamp,
   input wire logic diag_irq,
   input wire logic diag_log_valid,
   input wire logic [7:0] diag_log_code,
   input wire logic self_reset_req,
   input wire logic default_mode,
   input wire logic accept_multipoint_param,
   input wire logic accept_ethernet_param,
   input wire logic station_addr_force,
   input wire logic [6:0] station_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] lamps;
   assign lamps = {group_fault_lamp, run_lamp, stop_lamp, backplane_bus_lamp, transmit_lamp, receive_lamp};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   sequence s_restart;
      self_reset_req ##1 (lamps == LAMPS_ALL && !self_reset_req);
   endsequence
   sequence s_alarm;
      diag_irq ##1 group_fault_lamp;
   endsequence
   irq_log_a: assert property (diag_irq |-> diag_log_valid)
      else $error("interrupt without log entry");
   log_code_a: assert property (diag_log_valid |-> diag_log_code == $past(problem_code))
      else $error("logged code differs from problem code");
   irq_cause_a: assert property (diag_irq |-> $past(problem_valid))
      else $error("interrupt without a problem");
   irq_lamp_a: assert property (diag_irq && !$past(outcome_valid) |-> s_alarm)
      else $error("fault lamp not lit after problem");
   accept_pair_a: assert property (accept_multipoint_param == accept_ethernet_param)
      else $error("parameter paths disagree");
   addr_force_a: assert property (station_addr_force |-> station_addr == DEFAULT_STATION_ADDR && default_mode)
      else $error("forced station address wrong");
   addr_idle_a: assert property (!station_addr_force |-> station_addr == STATION_ADDR_NONE)
      else $error("station address set while not forced");
   restart_a: assert property (self_reset_req |-> s_restart)
      else $error("self reset did not restart at phase one");
   run_flash_a: assert property ($changed(run_lamp) && !default_mode && !$past(default_mode) && !accept_multipoint_param
      && !$past(accept_multipoint_param) |-> stop_lamp)
      else $error("run lamp toggled with stop lamp dark");
endmodule : spli_properties

// ---- testbench/spli_panel_model.sv ----
// Purpose: operator at the front panel and host interrupt counter
// Assumes: press is raised by the bench before power on
// Notes: button follows the lamp blink, as a person watching it would
module spli_panel_model (
   input wire logic clock,
   input wire logic press,
   input wire logic group_fault_lamp,
   input wire logic diag_irq,
   output logic reset_button,
   output logic [7:0] irq_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic dark_seen;
   initial begin
      reset_button = 1'h0;
      dark_seen = 1'h0;
      irq_count = 8'h00;
   end
   // let go only once the fault lamp is back on after its blink
   always @(negedge clock) begin
      if (!press) begin
         reset_button <= 1'h0;
         dark_seen <= 1'h0;
      end else if (!dark_seen) begin
         reset_button <= 1'h1;
         dark_seen <= reset_button && !group_fault_lamp;
      end else if (group_fault_lamp) begin
         reset_button <= 1'h0;
      end
   end
   always @(posedge clock) begin
      if (diag_irq) begin
         irq_count <= irq_count + 8'h01;
      end
   end
endmodule : spli_panel_model

// ---- testbench/tb.sv ----
// Purpose: self checking bench of the startup lamp indicator
// Assumes: shortened flash and second counts
// Notes: lamp vector is fault, run, stop, backplane, transmit, receive
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic out; logic [3:0] num; logic [5:0] exp; logic [5:0] mask;} spli_row_t;
   logic clock = 1'h0, arst_n = 1'h0, phase_valid = 1'h0, outcome_valid = 1'h0, problem_valid = 1'h0;
   logic param_received = 1'h0, fixed_addr_host = 1'h0, press = 1'h0;
   logic [3:0] phase_num = 4'h0;
   logic [2:0] outcome_code = 3'h0;
   logic [7:0] problem_code = 8'h00;
   logic [2:0] normal_lamps = 3'h5;
   logic group_fault_lamp, run_lamp, stop_lamp, backplane_bus_lamp, transmit_lamp, receive_lamp;
   logic diag_irq, diag_log_valid, self_reset_req, default_mode, station_addr_force, reset_button;
   logic accept_multipoint_param, accept_ethernet_param;
   logic [7:0] diag_log_code, irq_count, n;
   logic [6:0] station_addr;
   logic [5:0] lamps;
   int err_count = 0;
   int num_checks = 0;
   realtime t0;
   spli_row_t rows [19] = '{{1'h0, 4'h1, 6'h3F, 6'h00}, {1'h0, 4'h2, 6'h1F, 6'h00}, {1'h0, 4'h3, 6'h0F, 6'h00},
      {1'h0, 4'h4, 6'h07, 6'h00}, {1'h0, 4'h5, 6'h08, 6'h10}, {1'h0, 4'h6, 6'h0C, 6'h10},
      {1'h0, 4'h7, 6'h0A, 6'h10}, {1'h0, 4'h8, 6'h0E, 6'h10}, {1'h0, 4'h9, 6'h09, 6'h10},
      {1'h0, 4'hA, 6'h0D, 6'h10}, {1'h0, 4'hB, 6'h0B, 6'h10}, {1'h0, 4'hC, 6'h0F, 6'h10},
      {1'h0, 4'hD, 6'h0F, 6'h10}, {1'h1, 4'h0, 6'h15, 6'h00}, {1'h1, 4'h1, 6'h2A, 6'h00},
      {1'h1, 4'h2, 6'h09, 6'h06}, {1'h1, 4'h3, 6'h0C, 6'h03}, {1'h1, 4'h4, 6'h08, 6'h07},
      {1'h1, 4'h5, 6'h0A, 6'h10}};
   assign lamps = {group_fault_lamp, run_lamp, stop_lamp, backplane_bus_lamp, transmit_lamp, receive_lamp};
   always #5 clock = ~clock;
   spli_top #(.HALF_CYCLES(4), .SEC_CYCLES(16)) i_dut (.*);
   spli_panel_model i_panel (.*);
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic do_reset();
      arst_n = 1'h0;
      repeat (20) @(negedge clock);
      chk("reset lamps", 8'h3F, {2'h0, lamps});
      arst_n = 1'h1;
      repeat (3) @(negedge clock);
   endtask : do_reset
   // one pulse, then two edges for state and lamp registers
   task automatic pulse(input logic [3:0] num, input logic out);
      @(negedge clock);
      if (out) begin
         outcome_valid = 1'h1;
         outcome_code = num[2:0];
      end else begin
         phase_valid = 1'h1;
         phase_num = num;
      end
      @(negedge clock);
      phase_valid = 1'h0;
      outcome_valid = 1'h0;
      repeat (2) @(negedge clock);
   endtask : pulse
   task automatic problem(input logic [7:0] code);
      @(negedge clock);
      problem_valid = 1'h1;
      problem_code = code;
      @(negedge clock);
      problem_valid = 1'h0;
      repeat (2) @(negedge clock);
   endtask : problem
   // flashing lamps must each go both ways and always agree with one another
   task automatic check_flash(input logic [5:0] mask);
      logic [5:0] hi;
      logic [5:0] lo;
      logic bad;
      hi = 6'h00;
      lo = 6'h00;
      bad = 1'h0;
      repeat (16) begin
         @(negedge clock);
         hi = hi | (lamps & mask);
         lo = lo | (~lamps & mask);
         bad = bad | ((lamps & mask) !== 6'h00 && (lamps & mask) !== mask);
      end
      chk("flash", {2'h0, mask}, {2'h0, hi & lo & {6{!bad}}});
   endtask : check_flash
   initial begin
      repeat (5000) @(posedge clock);
      err_count++;
      summarize();
   end
   initial begin
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].out) begin
            do_reset();
            pulse(4'h7, 1'h0);
         end
         pulse(rows[i].num, rows[i].out);
         chk("lamps", {2'h0, rows[i].exp & ~rows[i].mask}, {2'h0, lamps & ~rows[i].mask});
         if (rows[i].mask != 6'h00) check_flash(rows[i].mask);
      end
      // default startup: button held through power on
      fixed_addr_host = 1'h1;
      press = 1'h1;
      do_reset();
      n = 8'h00;
      while (group_fault_lamp !== 1'h0 && n < 8'h32) begin
         @(negedge clock);
         n++;
      end
      chk("blink off", 8'h00, {7'h00, group_fault_lamp});
      while (group_fault_lamp !== 1'h1 && n < 8'h64) begin
         @(negedge clock);
         n++;
      end
      chk("blink on", 8'h01, {7'h00, group_fault_lamp});
      repeat (2) @(negedge clock);
      chk("default mode", 8'h01, {7'h00, default_mode});
      pulse(4'h7, 1'h0);
      pulse(4'h0, 1'h1);
      chk("default lamps", 8'h07, {2'h0, lamps & 6'h27});
      check_flash(6'h18);
      chk("station addr", 8'h03, {1'h0, station_addr});
      chk("accept", 8'h03, {6'h00, accept_multipoint_param, accept_ethernet_param});
      // problem reporting, then refusal outside the phases
      press = 1'h0;
      fixed_addr_host = 1'h0;
      do_reset();
      pulse(4'h6, 1'h0);
      n = irq_count;
      problem(8'hA5);
      chk("log code", 8'hA5, diag_log_code);
      chk("fault lamp", 8'h01, {7'h00, group_fault_lamp});
      chk("irq count", 8'h01, irq_count - n);
      pulse(4'h2, 1'h1);
      problem(8'h5A);
      chk("irq refused", 8'h01, irq_count - n);
      // new parameter set: acknowledge flashing, then self reset
      @(negedge clock);
      param_received = 1'h1;
      t0 = $realtime;
      @(negedge clock);
      param_received = 1'h0;
      repeat (2) @(negedge clock);
      check_flash(6'h20);
      while (self_reset_req !== 1'h1 && $realtime - t0 < 6000.0) @(negedge clock);
      chk("countdown", 8'h01, {7'h00, ($realtime - t0) >= 3040.0 && ($realtime - t0) <= 3300.0});
      @(negedge clock);
      chk("restart lamps", 8'h3F, {2'h0, lamps});
      summarize();
   end
endmodule : tb
bind spli_top spli_properties i_props (.*);
